// ---- tc2_timer.sv ----
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`include "tc2_defs.svh"
// Notes on behaviour
// R1 - Run written zero stops and clears counter; written one starts counting.
// R2 - Three-bit clock field picks taps; 110 reserved, 111 is the input pin.
// R3 - Codes 000/001 use slow taps in slow/sleep; 010/011 absent; 101 normal (code also stops 101 in slow/sleep).
// R4 - Software picks 100 only in second slow mode, timer operation.
// R5 - Mode bit zero gives timer or event counting, one gives window mode.
// R6 - Sixteen-bit compare value is compared against the up-counter.
// R7 - Software writes compare low byte first, then high byte.
// R8 - A lone low or lone high byte write leaves compare unchanged.
// R9 - Old compare value stays in use until the high byte completes it.
// R10 - Software changes mode and clock only while run is zero.
// R11 - Compare must exceed one; upper five bits exceed one at warm-up.
// R12 - Control bits 7, 6 and 1 read as undefined.
// R13 - Stop power state entry clears run; software must set it again.
// R14 - Timer mode counts internal clock; match interrupts, clears, continues.
// R15 - Event mode counts pin rising edges; match acts on next falling edge.
// R16 - Window mode counts internal clock while pin high; match clears.
// R17 - Fast clock in second slow mode matches on upper five bits only.
// R18 - Reset leaves counter stopped and cleared, run reading zero.
module tc2_timer
  import tc2_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             low_freq_tick_i,
  input  wire logic             slow_mode_i,
  input  wire logic             sleep_mode_i,
  input  wire logic             second_slow_mode_i,
  input  wire logic             stop_entry_i,
  input  wire logic             count_input_pin_i,
  output logic                  match_interrupt_o,
  output logic                  running_o
);

  logic                     run_control;
  tc2_clk_sel_t             source_clock_select;
  logic                     operating_mode_select;
  logic                     divider_tap_select;
  logic [CNT_W-1:0]         compare_value_reg;
  logic [7:0]               compare_value_low;
  logic                     low_pending;
  logic [CNT_W-1:0]         counter;
  logic [`TC2_DIV_FC_W-1:0] fc_div;
  logic [`TC2_DIV_FS_W-1:0] fs_div;
  logic                     pin_q;
  tc2_state_t               state;
  logic                     wr_ctl;
  logic                     wr_lo;
  logic                     wr_hi;
  logic                     wr_cfg;
  logic                     bus_req;
  logic                     tick;
  logic                     fast_sel;
  logic                     pin_rise;
  logic                     pin_fall;
  logic                     hit;
  logic                     low_power;
  logic [CNT_W-1:0]         next_count;

  // Named copy so the reset fields can be sliced
  localparam logic [7:0]    CTL_RESET = `TC2_RST_CONTROL;

  // Single-cycle bus answer, one wait state
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctl  = bus_req && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == `TC2_OFS_CONTROL;
  assign wr_lo   = bus_req && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == `TC2_OFS_CMP_LOW;
  assign wr_hi   = bus_req && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == `TC2_OFS_CMP_HIGH;
  assign wr_cfg  = bus_req && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == `TC2_OFS_CONFIG;
  assign low_power = slow_mode_i || sleep_mode_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        // Undefined bits 7, 6, 1 are returned as zero [R12]
        `TC2_OFS_CONTROL:  wb_dat_o <= {26'h0, run_control,
                                        source_clock_select, 1'b0,
                                        operating_mode_select};
        `TC2_OFS_CMP_LOW:  wb_dat_o <= {24'h0, compare_value_reg[7:0]};
        `TC2_OFS_CMP_HIGH: wb_dat_o <= {24'h0, compare_value_reg[15:8]};
        `TC2_OFS_COUNT:    wb_dat_o <= {16'h0, counter};
        `TC2_OFS_CONFIG:   wb_dat_o <= {31'h0, divider_tap_select};
        default:           wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; stop entry wins over a same-cycle write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_control           <= CTL_RESET[`TC2_RUN_BIT]; // [R18]
      source_clock_select   <= tc2_clk_sel_t'(
                               CTL_RESET[`TC2_CLK_MSB:`TC2_CLK_LSB]);
      operating_mode_select <= CTL_RESET[`TC2_MODE_BIT];
    end else begin
      if (wr_ctl) begin
        run_control           <= wb_dat_i[`TC2_RUN_BIT]; // [R1]
        // Fields taken as written; changing them while running is unsafe
        source_clock_select   <= tc2_clk_sel_t'(
                                 wb_dat_i[`TC2_CLK_MSB:`TC2_CLK_LSB]);
        operating_mode_select <= wb_dat_i[`TC2_MODE_BIT]; // [R5]
      end
      if (stop_entry_i) begin
        run_control <= 1'b0; // [R13]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      divider_tap_select <= `TC2_RST_DVSEL;
    end else if (wr_cfg) begin
      divider_tap_select <= wb_dat_i[`TC2_DVSEL_BIT];
    end
  end

  // Compare value only changes as a whole pair [R6]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_value_reg <= `TC2_RST_COMPARE;
      compare_value_low <= 8'h00;
      low_pending       <= 1'b0;
    end else if (wr_lo) begin
      compare_value_low <= wb_dat_i[7:0];
      low_pending       <= 1'b1; // [R9]
    end else if (wr_hi) begin
      low_pending <= 1'b0;
      if (low_pending) begin
        compare_value_reg <= {wb_dat_i[7:0], compare_value_low}; // [R9]
      end // A lone high write is dropped [R8]
    end
  end

  // Free-running prescalers for both clock families
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fc_div <= '0;
      fs_div <= '0;
    end else begin
      fc_div <= fc_div + 1'b1;
      if (low_freq_tick_i) begin
        fs_div <= fs_div + 1'b1;
      end
    end
  end

  // Tap pulses mark the prescaler passing each power-of-two boundary
  always_comb begin
    tick     = 1'b0;
    fast_sel = 1'b0;
    case (source_clock_select) // [R2]
      TC2_CK_TAP0: begin
        if (low_power || divider_tap_select) begin
          tick = low_freq_tick_i
                 && &fs_div[`TC2_TAP_FS_15-1:0]; // [R3]
        end else begin
          tick = &fc_div[`TC2_TAP_FC_23-1:0];
        end
      end
      TC2_CK_TAP1: begin
        if (low_power || divider_tap_select) begin
          tick = low_freq_tick_i && &fs_div[`TC2_TAP_FS_5-1:0]; // [R3]
        end else begin
          tick = &fc_div[`TC2_TAP_FC_13-1:0];
        end
      end
      TC2_CK_TAP2: tick = !low_power && &fc_div[`TC2_TAP_FC_8-1:0]; // [R3]
      TC2_CK_TAP3: tick = !low_power && &fc_div[`TC2_TAP_FC_3-1:0]; // [R3]
      TC2_CK_FAST: begin
        // Only meaningful in second slow timer operation [R4]
        fast_sel = second_slow_mode_i && !sleep_mode_i;
        tick     = fast_sel;
      end
      TC2_CK_SLOW:     tick = !low_power && low_freq_tick_i; // [R3]
      TC2_CK_RESERVED: tick = 1'b0;
      TC2_CK_EXTERNAL: tick = 1'b0;
      default:         tick = 1'b0;
    endcase
  end

  assign pin_rise = count_input_pin_i && !pin_q;
  assign pin_fall = !count_input_pin_i && pin_q;

  // Warm-up use ignores the low eleven bits [R17]
  always_comb begin
    next_count = counter + 1'b1;
    if (fast_sel) begin
      hit = next_count[CNT_W-1:`TC2_WARM_LSB]
            == compare_value_reg[CNT_W-1:`TC2_WARM_LSB];
    end else begin
      hit = next_count == compare_value_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= count_input_pin_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= TC2_ST_IDLE;
    end else begin
      case (state)
        TC2_ST_IDLE:  if (run_control) state <= TC2_ST_COUNT;
        TC2_ST_COUNT: if (!run_control) state <= TC2_ST_IDLE; // [R1]
        default:      state <= TC2_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter           <= '0; // [R18]
      match_interrupt_o <= 1'b0;
    end else begin
      match_interrupt_o <= 1'b0;
      if (state != TC2_ST_COUNT || !run_control) begin
        counter <= '0; // [R1] [R13]
      end else if (operating_mode_select) begin
        if (tick && count_input_pin_i) begin // [R16]
          counter           <= hit ? '0 : next_count;
          match_interrupt_o <= hit;
        end
      end else if (source_clock_select == TC2_CK_EXTERNAL) begin
        if (pin_rise) begin
          counter <= next_count; // [R15]
        end else if (pin_fall && counter == compare_value_reg) begin
          counter           <= '0; // [R15]
          match_interrupt_o <= 1'b1;
        end
      end else if (tick) begin
        counter           <= hit ? '0 : next_count; // [R14]
        match_interrupt_o <= hit; // [R14] [R17]
      end
    end
  end

  assign running_o = state == TC2_ST_COUNT;

endmodule

// ---- tc2_defs.svh ----
`ifndef TC2_DEFS_SVH
`define TC2_DEFS_SVH

// Register byte offsets on the bus
`define TC2_OFS_CONTROL     8'h00
`define TC2_OFS_CMP_LOW     8'h04
`define TC2_OFS_CMP_HIGH    8'h08
`define TC2_OFS_COUNT       8'h0C
`define TC2_OFS_CONFIG      8'h10

// Control register fields
`define TC2_RUN_BIT         5
`define TC2_CLK_MSB         4
`define TC2_CLK_LSB         2
`define TC2_MODE_BIT        0

// Config register fields
`define TC2_DVSEL_BIT       0

// Reset values
`define TC2_RST_CONTROL     8'h00
`define TC2_RST_COMPARE     16'hFFFF
`define TC2_RST_DVSEL       1'b0

// Divider tap exponents
`define TC2_DIV_FC_W        23
`define TC2_DIV_FS_W        15
`define TC2_TAP_FC_23       23
`define TC2_TAP_FC_13       13
`define TC2_TAP_FC_8        8
`define TC2_TAP_FC_3        3
`define TC2_TAP_FS_15       15
`define TC2_TAP_FS_5        5

// Bits kept when the fast clock counts in second slow mode
`define TC2_WARM_LSB        11

`endif

// ---- tc2_pkg.sv ----
package tc2_pkg;

  typedef enum logic [2:0] {
    TC2_CK_TAP0     = 3'h0,
    TC2_CK_TAP1     = 3'h1,
    TC2_CK_TAP2     = 3'h2,
    TC2_CK_TAP3     = 3'h3,
    TC2_CK_FAST     = 3'h4,
    TC2_CK_SLOW     = 3'h5,
    TC2_CK_RESERVED = 3'h6,
    TC2_CK_EXTERNAL = 3'h7
  } tc2_clk_sel_t;

  typedef enum logic [1:0] {
    TC2_ST_IDLE   = 2'b01,
    TC2_ST_COUNT  = 2'b10
  } tc2_state_t;

endpackage

// ---- tc2_assertions.sv ----
`timescale 1ns/10ps
module tc2_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        stop_entry_i,
  input wire logic        match_interrupt_o,
  input wire logic        running_o
);
  wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire ctl  = take & (wb_adr_i == 8'h00);
  wire wr   = ctl & wb_we_i & wb_sel_i[0] & ~stop_entry_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  a_run_start: assert property (
    wr && wb_dat_i[5] |-> ##[1:2] running_o)
    else $error("run write did not start counter");
  a_run_stop: assert property (
    wr && !wb_dat_i[5] |-> ##[1:2] !running_o)
    else $error("stop write left counter running");
  a_stop_entry: assert property (
    stop_entry_i |-> ##[1:2] !running_o)
    else $error("stop state entry did not halt counter");
  a_irq_pulse: assert property (
    match_interrupt_o |=> !match_interrupt_o)
    else $error("match interrupt longer than one cycle");
  a_irq_running: assert property (
    match_interrupt_o |-> $past(running_o))
    else $error("match interrupt while stopped");
  a_idle_quiet: assert property (
    (!running_o) [*3] |-> !match_interrupt_o)
    else $error("interrupt from a halted counter");
  a_ctl_spare: assert property (
    ctl && !wb_we_i |=> wb_dat_o[7:6] == 2'h0 && !wb_dat_o[1])
    else $error("spare control bits not zero");
  a_reset_quiet: assert property (
    $fell(rst_i) |-> !running_o && !match_interrupt_o)
    else $error("counter active after reset");
endmodule
bind tc2_timer tc2_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .stop_entry_i, .match_interrupt_o, .running_o);

// ---- tc2_pin_model.sv ----
`timescale 1ns/10ps
module tc2_pin_model (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       en_i,
  input wire logic       hi_i,
  input wire logic [3:0] half_i,
  output logic           pin_o
);
  logic [3:0] cnt;
  logic       tog;
  // Levels last several cycles so the pin sampler sees every edge
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      cnt <= 4'h0;
      tog <= 1'b0;
    end else if (cnt == half_i - 4'h1) begin
      cnt <= 4'h0;
      tog <= ~tog;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  assign pin_o = hi_i | tog;
endmodule

// ---- tc2_timer_test.sv ----
`timescale 1ns/10ps
module tc2_timer_test;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, r, seed;
  logic        low_freq_tick_i, slow_mode_i, sleep_mode_i, en, hi;
  logic        second_slow_mode_i, stop_entry_i, count_input_pin_i;
  logic        match_interrupt_o, running_o;
  int          failures, checks, k, n, m, u, i;
  int          codes[4] = '{2, 3, 5, 6};
  tc2_timer dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .low_freq_tick_i, .slow_mode_i, .sleep_mode_i, .second_slow_mode_i,
    .stop_entry_i, .count_input_pin_i, .match_interrupt_o, .running_o);
  tc2_pin_model pin (.clk_i, .rst_i, .en_i(en), .hi_i(hi),
    .half_i(4'h3), .pin_o(count_input_pin_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Low clock ticks every other cycle, so undivided periods stay exact
  always @(posedge clk_i) low_freq_tick_i <= ~low_freq_tick_i;
  task results;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic int rnd(input int lo, input int sp);
    seed = xs(seed);
    return lo + int'(seed % sp);
  endfunction
  function automatic logic [31:0] ctl(input int run, code, mode);
    return {26'h0, 1'(run), 3'(code), 1'b0, 1'(mode)};
  endfunction
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (j = 0; j < 20 && wb_ack_o !== 1'b1; j++) @(posedge clk_i);
    if (j == 20) begin
      failures++;
      results();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task irq(input int lim);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (match_interrupt_o !== 1'b1 && k < lim);
    if (match_interrupt_o !== 1'b1) begin
      failures++;
      results();
    end
  endtask
  // Counts pulses over a fixed window where none may come
  task quiet(input int len);
    k = 0;
    repeat (len) begin
      @(posedge clk_i);
      if (match_interrupt_o !== 1'b0) k++;
    end
    chk(k, 0);
  endtask
  // First interval after a change is skewed, so judge the second
  task per(input int lim, input int e);
    irq(lim);
    irq(lim);
    chk(k, e);
  endtask
  task cmp(input logic [7:0] lo, input logic [7:0] hb);
    wb(1'b1, 8'h04, {24'h0, lo});
    wb(1'b1, 8'h08, {24'h0, hb});
  endtask
  task run(input int code, input int mode);
    // Stop first with the old fields, then change them while stopped
    wb(1'b0, 8'h00, 0);
    wb(1'b1, 8'h00, r & ~32'h20);
    wb(1'b1, 8'h00, ctl(0, code, mode));
    wb(1'b1, 8'h00, ctl(1, code, mode));
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {low_freq_tick_i, slow_mode_i, sleep_mode_i, en, hi} = '0;
    {second_slow_mode_i, stop_entry_i} = '0;
    wb_sel_i = 4'hF;
    rst_i = 1'b1;
    seed = 32'h7C42;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 8'h00, 0);
    chk(r, 0);
    wb(1'b0, 8'h14, 0);
    chk(r, 0);
    n = rnd(2, 8);
    // Above the running count, so the new compare is still ahead
    m = n + rnd(1, 8);
    cmp(8'(n), 8'h00);
    run(3, 0);
    per(500, n * 8);
    wb(1'b1, 8'h04, m);
    per(500, n * 8);
    wb(1'b1, 8'h08, 0);
    per(500, m * 8);
    wb(1'b1, 8'h08, 1);
    per(500, m * 8);
    wb(1'b1, 8'h00, ctl(0, 3, 0));
    wb(1'b0, 8'h0C, 0);
    chk(r, 0);
    run(3, 0);
    stop_entry_i <= 1'b1;
    @(posedge clk_i);
    stop_entry_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    wb(1'b0, 8'h00, 0);
    chk(r, ctl(0, 3, 0));
    wb(1'b0, 8'h0C, 0);
    chk(r, 0);
    slow_mode_i <= 1'b1;
    second_slow_mode_i <= 1'b1;
    u = rnd(2, 2);
    cmp(8'(rnd(0, 256)), {u[4:0], 3'(rnd(0, 8))});
    run(4, 0);
    per(7000, u * 2048);
    second_slow_mode_i <= 1'b0;
    for (i = 0; i < 4; i++) begin
      run(codes[i], 0);
      repeat (40) @(posedge clk_i);
      wb(1'b0, 8'h0C, 0);
      chk(r, 0);
      wb(1'b1, 8'h00, ctl(0, codes[i], 0));
    end
    cmp(8'(n), 8'h00);
    run(1, 0);
    per(1500, n * 64);
    slow_mode_i <= 1'b0;
    wb(1'b1, 8'h10, 1);
    wb(1'b0, 8'h10, 0);
    chk(r, 1);
    run(1, 0);
    per(1500, n * 64);
    wb(1'b1, 8'h10, 0);
    run(5, 0);
    per(500, n * 2);
    en <= 1'b1;
    run(7, 0);
    per(600, n * 6);
    en <= 1'b0;
    run(3, 1);
    quiet(300);
    hi <= 1'b1;
    per(500, n * 8);
    results();
  end
endmodule
